// file: src/plscc_pkg.sv
/*
  Constants, register offsets and field positions of the PLL lock and
  sleep clocking controller.
  Assumes an APB master with 32-bit data and one aligned word per register.
*/
// Overview of operation
// - A changed crystal selection starts a PLL relock; same value does not.
// - PLL leaving power-down for normal operation starts a relock; on deep-sleep exit the code starts none.
// - Each relock loads lock counter with 0x1200, clocked by main oscillator.
// - PLL may not be system clock source before the lock time has expired; on deep-sleep exit the code reselects it at once.
// - Enable and select PLL together: stay on oscillator until lock, then switch.
// - Lock shows as raw status flag and may raise a maskable interrupt.
// - Run mode clocks processor and peripherals enabled by run gating registers.
// - Sleep stops processor and memory clocks, system clock stays unchanged.
// - Sleep gates by sleep registers with auto gating, else run registers.
// - Wait-for-interrupt enters sleep, or deep sleep when enabled; interrupt wakes.
// - Deep sleep gates by deep-sleep registers with auto gating, else run ones.
// - Deep sleep uses main oscillator unless config selects an internal one.
// - Deep sleep powers PLL down and uses divider override up to /16 or /64.
// - On deep-sleep exit restore clock source first, then reenable clocks.
// - Hibernate keeps only hibernation logic; wake restarts through power-on.
// - With debug port on, wake may run code before peripheral clocks return.
// - Secondary configuration fields apply only with its use bit set.
// - Crystal write loads PLL settings; clearing power-down enables the PLL.
// - PLL runs at 400 MHz, halved; divider equals field encoding plus one.
`default_nettype none
package plscc_pkg;
  localparam logic [11:0] OFF_RAW_STATUS   = 12'h050;
  localparam logic [11:0] OFF_INT_MASK     = 12'h054;
  localparam logic [11:0] OFF_MASKED_CLR   = 12'h058;
  localparam logic [11:0] OFF_CFG_PRIMARY  = 12'h060;
  localparam logic [11:0] OFF_PLL_SETTINGS = 12'h064;
  localparam logic [11:0] OFF_CFG_SECOND   = 12'h070;
  localparam logic [11:0] OFF_RUN_GATE     = 12'h100;
  localparam logic [11:0] OFF_SLEEP_GATE   = 12'h110;
  localparam logic [11:0] OFF_DEEP_GATE    = 12'h120;
  localparam logic [11:0] OFF_DEEP_CFG     = 12'h144;
  localparam logic [11:0] OFF_POWER_CTRL   = 12'h180;
  localparam logic [11:0] OFF_STATE        = 12'h184;

  localparam logic [31:0] RST_CFG_PRIMARY  = 32'h078e3ad1;
  localparam logic [31:0] RST_CFG_SECOND   = 32'h07802810;
  localparam logic [31:0] RST_GATE0        = 32'h00000040;
  localparam logic [31:0] RST_DEEP_CFG     = 32'h07800000;

  // Primary configuration fields
  localparam int P_OSC_LO = 4;
  localparam int P_CRYSTAL_SELECT_LO = 6;
  localparam int P_BYPASS = 11;
  localparam int P_PLL_POWER_DOWN = 13;
  localparam int P_USE_SYSTEM_DIVIDER = 22;
  localparam int P_DIV_LO = 23;
  localparam int P_AUTOGATE = 27;
  // Secondary configuration fields
  localparam int S_OSC_LO = 4;
  localparam int S_BYPASS = 11;
  localparam int S_PLL_POWER_DOWN = 13;
  localparam int S_DIV_LO = 23;
  localparam int S_USE = 31;
  // Deep-sleep configuration fields, main oscillator code and lock status bit
  localparam int D_OSC_LO = 4;
  localparam int D_DIV_LO = 23;
  localparam logic [2:0] OSC_MAIN = 3'h0;
  localparam int LOCK_BIT = 6;

  localparam logic [15:0] LOCK_LOAD = 16'h1200;

  typedef enum logic [1:0] {
    PLSCC_RUN   = 2'b00,
    PLSCC_SLEEP = 2'b01,
    PLSCC_DEEP  = 2'b10,
    PLSCC_WAKE  = 2'b11
  } plscc_mode_e;
endpackage : plscc_pkg
`default_nettype wire

// file: src/plscc_top.sv
/*
  PLL lock timing, clock source selection, per-peripheral gating and
  sleep/deep-sleep sequencing, with an APB register slave.
  Assumes mclk and the main oscillator cycle are the same clock, and that
  processor events (wait-for-interrupt, wake) arrive as one-cycle pulses.
*/
`default_nettype none
module plscc_top
  import plscc_pkg::*;
#(
  parameter int          NPERIPH  = 32,
  parameter logic [15:0] LOCK_CNT = LOCK_LOAD
) (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic      [31:0]        prdata,
  input  wire logic               waitForInterruptInstr,
  input  wire logic               deepSleepEnable,
  input  wire logic               wakeEvent,
  input  wire logic               debugAccessPort,
  output logic                    cpuClkEn,
  output logic      [NPERIPH-1:0] periphClkEn,
  output logic                    pllPowerDown,
  output logic                    pllSelected,
  output logic      [2:0]         oscSelect,
  output logic      [5:0]         sysDivider,
  output logic                    useDivider,
  output logic                    mainOscPowerDown,
  output logic                    hibernateReq,
  output logic                    pllLockIrq,
  output logic                    unclockedFault
);
  typedef struct packed {
    logic [31:0]  cfgPri;
    logic [31:0]  cfgSec;
    logic [31:0]  deepCfg;
    logic [NPERIPH-1:0] runGate;
    logic [NPERIPH-1:0] sleepGate;
    logic [NPERIPH-1:0] deepGate;
    logic         lockMask;
    logic         lockRaw;
    logic [15:0]  lockCnt;
    logic         pllReady;
    logic [4:0]   pllSettings;
    plscc_mode_e  mode;
    logic         hibReq;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
    logic         cpuEn;
    logic [NPERIPH-1:0] periphEn;
    logic         pllPd;
    logic         pllSel;
    logic [2:0]   osc;
    logic [5:0]   div;
    logic         useDiv;
    logic         moscPd;
    logic         irq;
    logic         fault;
  } plscc_state_s;

  plscc_state_s st_r;
  plscc_state_s st_nxt;

  logic useSec;
  logic effPwrdn;
  logic effBypass;
  logic [2:0] effOsc;
  logic [5:0] effDiv;
  logic apbAcc;
  logic apbWr;
  logic relock;
  logic [NPERIPH-1:0] gateSel;

  always_comb begin
    st_nxt = st_r;
    useSec    = st_r.cfgSec[S_USE];
    effPwrdn  = useSec ? st_r.cfgSec[S_PLL_POWER_DOWN]  : st_r.cfgPri[P_PLL_POWER_DOWN];
    effBypass = useSec ? st_r.cfgSec[S_BYPASS] : st_r.cfgPri[P_BYPASS];
    effOsc    = useSec ? st_r.cfgSec[S_OSC_LO +: 3] : {1'b0, st_r.cfgPri[P_OSC_LO +: 2]};
    // divider is field plus one, 6-bit wide field from secondary
    effDiv    = useSec ? st_r.cfgSec[S_DIV_LO +: 6] : {2'b00, st_r.cfgPri[P_DIV_LO +: 4]};
    apbAcc    = psel && penable && !st_r.pready;
    apbWr     = apbAcc && pwrite;
    relock    = 1'b0;

    st_nxt.pready  = apbAcc;
    st_nxt.pslverr = 1'b0;
    if (apbWr) begin
      case (paddr)
        OFF_CFG_PRIMARY: begin
          // relock on a changed crystal value, not on the same one
          if (pwdata[P_CRYSTAL_SELECT_LO +: 5] != st_r.cfgPri[P_CRYSTAL_SELECT_LO +: 5]) begin
            relock = 1'b1;
          end
          st_nxt.pllSettings = pwdata[P_CRYSTAL_SELECT_LO +: 5];
          st_nxt.cfgPri = pwdata;
          if (!useSec && st_r.cfgPri[P_PLL_POWER_DOWN] && !pwdata[P_PLL_POWER_DOWN]) begin
            relock = 1'b1;
          end
        end
        OFF_CFG_SECOND: begin
          if ((pwdata[S_USE] ? pwdata[S_PLL_POWER_DOWN] : st_r.cfgPri[P_PLL_POWER_DOWN]) == 1'b0 && effPwrdn) begin
            relock = 1'b1;
          end
          st_nxt.cfgSec = pwdata;
        end
        OFF_INT_MASK:   st_nxt.lockMask = pwdata[LOCK_BIT];
        OFF_MASKED_CLR: if (pwdata[LOCK_BIT]) st_nxt.lockRaw = 1'b0;
        OFF_RUN_GATE:   st_nxt.runGate = pwdata[NPERIPH-1:0];
        OFF_SLEEP_GATE: st_nxt.sleepGate = pwdata[NPERIPH-1:0];
        OFF_DEEP_GATE:  st_nxt.deepGate = pwdata[NPERIPH-1:0];
        OFF_DEEP_CFG:   st_nxt.deepCfg = pwdata;
        // hibernate request, wake is a full power-on reset
        OFF_POWER_CTRL: st_nxt.hibReq = pwdata[0];
        default:        st_nxt.pslverr = 1'b1;
      endcase
    end else if (apbAcc) begin
      case (paddr)
        OFF_RAW_STATUS:   st_nxt.prdata = {25'h0, st_r.lockRaw, 6'h0};
        OFF_INT_MASK:     st_nxt.prdata = {25'h0, st_r.lockMask, 6'h0};
        OFF_MASKED_CLR:   st_nxt.prdata = {25'h0, st_r.lockRaw && st_r.lockMask, 6'h0};
        OFF_CFG_PRIMARY:  st_nxt.prdata = st_r.cfgPri;
        OFF_PLL_SETTINGS: st_nxt.prdata = {27'h0, st_r.pllSettings};
        OFF_CFG_SECOND:   st_nxt.prdata = st_r.cfgSec;
        OFF_RUN_GATE:     st_nxt.prdata = 32'(st_r.runGate);
        OFF_SLEEP_GATE:   st_nxt.prdata = 32'(st_r.sleepGate);
        OFF_DEEP_GATE:    st_nxt.prdata = 32'(st_r.deepGate);
        OFF_DEEP_CFG:     st_nxt.prdata = st_r.deepCfg;
        OFF_POWER_CTRL:   st_nxt.prdata = {31'h0, st_r.hibReq};
        OFF_STATE:        st_nxt.prdata = {28'h0, st_r.pllReady, st_r.pllSel, st_r.mode};
        default: begin
          st_nxt.prdata  = 32'h0;
          st_nxt.pslverr = 1'b1;
        end
      endcase
    end

    // load lock counter on a trigger
    // reload clears ready; count down while nonzero
    if (relock) begin
      st_nxt.lockCnt  = LOCK_CNT;
      st_nxt.pllReady = 1'b0;
    end else if (st_r.lockCnt != 16'h0) begin
      st_nxt.lockCnt = st_r.lockCnt - 16'h1;
      if (st_r.lockCnt == 16'h1) begin
        st_nxt.pllReady = 1'b1;
        // raw lock flag, set wins over clear
        st_nxt.lockRaw  = 1'b1;
      end
    end

    case (st_r.mode)
      PLSCC_RUN: if (waitForInterruptInstr) begin
        st_nxt.mode = deepSleepEnable ? PLSCC_DEEP : PLSCC_SLEEP;
      end
      PLSCC_SLEEP: if (wakeEvent) st_nxt.mode = PLSCC_RUN;
      // restore clock first, gates a cycle later
      PLSCC_DEEP:  if (wakeEvent) st_nxt.mode = PLSCC_WAKE;
      PLSCC_WAKE:  st_nxt.mode = PLSCC_RUN;
      default:     st_nxt.mode = PLSCC_RUN;
    endcase

    gateSel = st_r.runGate;
    if (st_nxt.mode == PLSCC_SLEEP && st_r.cfgPri[P_AUTOGATE]) begin
      gateSel = st_r.sleepGate;
    end
    if ((st_nxt.mode == PLSCC_DEEP || st_nxt.mode == PLSCC_WAKE) && st_r.cfgPri[P_AUTOGATE]) begin
      gateSel = st_r.deepGate;
    end
    st_nxt.periphEn = gateSel;
    st_nxt.cpuEn = (st_nxt.mode == PLSCC_RUN);

    st_nxt.pllSel = !effBypass && !effPwrdn && st_nxt.pllReady;
    st_nxt.pllPd  = effPwrdn;
    st_nxt.osc    = effOsc;
    st_nxt.div    = effDiv;
    st_nxt.useDiv = st_r.cfgPri[P_USE_SYSTEM_DIVIDER];
    st_nxt.moscPd = 1'b0;
    if (st_nxt.mode == PLSCC_DEEP) begin
      st_nxt.osc    = st_r.deepCfg[D_OSC_LO +: 3];
      st_nxt.moscPd = st_r.deepCfg[D_OSC_LO +: 3] != OSC_MAIN;
      st_nxt.pllPd  = 1'b1;
      st_nxt.pllSel = 1'b0;
      st_nxt.div    = useSec ? st_r.deepCfg[D_DIV_LO +: 6]
                             : {2'b00, st_r.deepCfg[D_DIV_LO +: 4]};
    end
    st_nxt.irq = st_nxt.lockRaw && st_nxt.lockMask;
    // debug wake before clocks are back, peripheral access faults
    st_nxt.fault = debugAccessPort && (st_r.mode == PLSCC_WAKE) && apbAcc;

    if (!rst_n) begin
      st_nxt = '0;
      st_nxt.cfgPri = RST_CFG_PRIMARY;
      st_nxt.cfgSec = RST_CFG_SECOND;
      st_nxt.deepCfg = RST_DEEP_CFG;
      st_nxt.runGate = NPERIPH'(RST_GATE0);
      st_nxt.sleepGate = NPERIPH'(RST_GATE0);
      st_nxt.deepGate = NPERIPH'(RST_GATE0);
      st_nxt.periphEn = NPERIPH'(RST_GATE0);
      st_nxt.pllPd = 1'b1;
      st_nxt.cpuEn = 1'b1;
      st_nxt.mode = PLSCC_RUN;
    end
  end

  always_ff @(posedge mclk) begin
    st_r <= st_nxt;
  end

  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign prdata = st_r.prdata;
  assign cpuClkEn = st_r.cpuEn;
  assign periphClkEn = st_r.periphEn;
  assign pllPowerDown = st_r.pllPd;
  assign pllSelected = st_r.pllSel;
  assign oscSelect = st_r.osc;
  assign sysDivider = st_r.div;
  assign useDivider = st_r.useDiv;
  assign mainOscPowerDown = st_r.moscPd;
  assign hibernateReq = st_r.hibReq;
  assign pllLockIrq = st_r.irq;
  assign unclockedFault = st_r.fault;

  a_pll_sel_lock: assert property (@(posedge mclk) disable iff (!rst_n)
    pllSelected |-> st_r.pllReady) else $error("PLL selected before lock");
  a_lock_load: assert property (@(posedge mclk) disable iff (!rst_n)
    relock |=> st_r.lockCnt == LOCK_CNT && !st_r.pllReady) else $error("bad lock reload");
  a_lock_dec: assert property (@(posedge mclk) disable iff (!rst_n)
    (!relock && st_r.lockCnt > 16'h1) |=> st_r.lockCnt == $past(st_r.lockCnt) - 16'h1)
    else $error("lock counter not decrementing");
  a_lock_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    (!relock && st_r.lockCnt == 16'h1) |=> st_r.lockRaw) else $error("lock flag missing");
  a_cpu_sleep: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_r.mode != PLSCC_RUN) |-> !cpuClkEn) else $error("cpu clocked asleep");
  a_deep_pll: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_r.mode == PLSCC_DEEP) |-> pllPowerDown && !pllSelected) else $error("PLL on deep");
  a_deep_wake: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_r.mode == PLSCC_DEEP && wakeEvent) |=> st_r.mode == PLSCC_WAKE ##1 cpuClkEn)
    else $error("deep wake order");
  a_wfi_enter: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_r.mode == PLSCC_RUN && waitForInterruptInstr) |=> !cpuClkEn) else $error("no sleep");
  // interrupt is raw flag and mask
  a_lock_irq: assert property (@(posedge mclk) disable iff (!rst_n)
    pllLockIrq == (st_r.lockRaw && st_r.lockMask)) else $error("lock irq mismatch");
  // main oscillator off only in deep sleep on another source
  a_deep_osc: assert property (@(posedge mclk) disable iff (!rst_n)
    mainOscPowerDown |-> (st_r.mode == PLSCC_DEEP && oscSelect != OSC_MAIN))
    else $error("main oscillator off outside deep sleep");
  c_relock: cover property (@(posedge mclk) relock ##[1:10] st_r.lockCnt != 16'h0);
  c_deep: cover property (@(posedge mclk) st_r.mode == PLSCC_DEEP);
  c_lock: cover property (@(posedge mclk) pllSelected);
endmodule // plscc_top
`default_nettype wire

// file: verification/plscc_top_bench.sv
/*
  Self-checking bench for the PLL lock and sleep clocking controller.
  Assumes the one-wait-state APB slave; sets the design lock count to a shortened 16.
*/
`default_nettype none
module plscc_top_bench import plscc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          LOCKN   = 16;
  localparam logic [31:0] CFG_PLL = (RST_CFG_PRIMARY & ~32'h07802800) | 32'h01c00000;
  localparam logic [31:0] CFG_X   = CFG_PLL ^ 32'h00000040;
  localparam logic [31:0] CFG_AG  = CFG_X | 32'h08000000;
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, periphClkEn, rd;
  logic        wait_for_interrupt_instr, dse, wake, debug_access_port, cpuClkEn, pllPowerDown, pllSelected;
  logic        useDivider, mainOscPowerDown, hibernateReq, pllLockIrq, unclockedFault, er;
  logic [2:0]  oscSelect;
  logic [5:0]  sysDivider;
  int          n_fail, num_checks;

  plscc_top #(.NPERIPH(32), .LOCK_CNT(16'(LOCKN))) dut (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .waitForInterruptInstr(wait_for_interrupt_instr), .deepSleepEnable(dse), .wakeEvent(wake),
    .debugAccessPort(debug_access_port), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
    .pllPowerDown(pllPowerDown), .pllSelected(pllSelected), .oscSelect(oscSelect),
    .sysDivider(sysDivider), .useDivider(useDivider), .mainOscPowerDown(mainOscPowerDown),
    .hibernateReq(hibernateReq), .pllLockIrq(pllLockIrq), .unclockedFault(unclockedFault)
  );

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Request held until pready is sampled high, then released
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic evt(input logic isWake);
    if (isWake) wake <= 1'b1;
    else wait_for_interrupt_instr <= 1'b1;
    @(posedge mclk);
    wake <= 1'b0;
    wait_for_interrupt_instr <= 1'b0;
    cyc(4);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic t_reset;
    logic [11:0] offs [5];
    logic [31:0] vals [5];
    offs = '{OFF_CFG_PRIMARY, OFF_CFG_SECOND, OFF_RUN_GATE, OFF_DEEP_CFG, OFF_RAW_STATUS};
    vals = '{RST_CFG_PRIMARY, RST_CFG_SECOND, RST_GATE0, RST_DEEP_CFG, 32'h0};
    chk("cpuClkEn", 32'h1, 32'(cpuClkEn));
    chk("pllPowerDown", 32'h1, 32'(pllPowerDown));
    chk("pllSelected", 32'h0, 32'(pllSelected));
    chk("periphClkEn", RST_GATE0, periphClkEn);
    chk("unclockedFault", 32'h0, 32'(unclockedFault));
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, offs[i], 32'h0);
      chk("reset value", vals[i], rd);
    end
    apb(1'b0, 12'h200, 32'h0);
    chk("unmapped err", 32'h1, 32'(er));
    chk("unmapped data", 32'h0, rd);
    $display("test reset done");
  endtask

  task automatic t_lock;
    apb(1'b1, OFF_CFG_PRIMARY, CFG_PLL);
    chk("pllSelected early", 32'h0, 32'(pllSelected));
    chk("useDivider", 32'h1, 32'(useDivider));
    apb(1'b0, OFF_RAW_STATUS, 32'h0);
    chk("lock flag early", 32'h0, rd & 32'h40);
    cyc(LOCKN + 4);
    chk("pllSelected locked", 32'h1, 32'(pllSelected));
    chk("pllPowerDown", 32'h0, 32'(pllPowerDown));
    chk("sysDivider", 32'h3, 32'(sysDivider));
    apb(1'b0, OFF_RAW_STATUS, 32'h0);
    chk("lock flag", 32'h40, rd & 32'h40);
    chk("irq masked", 32'h0, 32'(pllLockIrq));
    apb(1'b1, OFF_INT_MASK, 32'h40);
    chk("irq enabled", 32'h1, 32'(pllLockIrq));
    apb(1'b1, OFF_MASKED_CLR, 32'h40);
    chk("irq cleared", 32'h0, 32'(pllLockIrq));
    $display("test lock done");
  endtask

  task automatic t_crystal;
    apb(1'b1, OFF_CFG_PRIMARY, CFG_PLL);
    chk("same crystal", 32'h1, 32'(pllSelected));
    apb(1'b1, OFF_CFG_PRIMARY, CFG_X);
    chk("new crystal", 32'h0, 32'(pllSelected));
    cyc(LOCKN - 8);
    chk("still counting", 32'h0, 32'(pllSelected));
    cyc(12);
    chk("relocked", 32'h1, 32'(pllSelected));
    $display("test crystal done");
  endtask

  task automatic t_sleep;
    apb(1'b1, OFF_RUN_GATE, 32'ha5);
    apb(1'b1, OFF_SLEEP_GATE, 32'h5a);
    apb(1'b1, OFF_DEEP_GATE, 32'h3c);
    chk("run gating", 32'ha5, periphClkEn);
    evt(1'b0);
    chk("sleep cpu", 32'h0, 32'(cpuClkEn));
    chk("sleep no autogate", 32'ha5, periphClkEn);
    chk("sleep source", 32'h1, 32'(pllSelected));
    chk("sleep divider", 32'h3, 32'(sysDivider));
    evt(1'b1);
    chk("woken cpu", 32'h1, 32'(cpuClkEn));
    apb(1'b1, OFF_CFG_PRIMARY, CFG_AG);
    evt(1'b0);
    chk("sleep autogate", 32'h5a, periphClkEn);
    evt(1'b1);
    $display("test sleep done");
  endtask

  task automatic t_deep;
    int n;
    apb(1'b1, OFF_DEEP_CFG, 32'h03800010);
    dse <= 1'b1;
    evt(1'b0);
    chk("deep cpu", 32'h0, 32'(cpuClkEn));
    chk("deep gating", 32'h3c, periphClkEn);
    chk("deep pll off", 32'h1, 32'(pllPowerDown));
    chk("deep divider", 32'h7, 32'(sysDivider));
    chk("deep osc", 32'h1, 32'(oscSelect));
    chk("main osc off", 32'h1, 32'(mainOscPowerDown));
    dse <= 1'b0;
    evt(1'b1);
    n = 0;
    while (cpuClkEn !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    chk("restored divider", 32'h3, 32'(sysDivider));
    chk("restored osc", 32'h0, 32'(mainOscPowerDown));
    cyc(LOCKN + 8);
    chk("restored pll", 32'h1, 32'(pllSelected));
    chk("restored gating", 32'ha5, periphClkEn);
    $display("test deep sleep done");
  endtask

  task automatic t_second;
    apb(1'b1, OFF_CFG_SECOND, (RST_CFG_SECOND & ~32'h1f800000) | 32'h10000000);
    chk("second unused", 32'h3, 32'(sysDivider));
    apb(1'b1, OFF_CFG_SECOND, (RST_CFG_SECOND & ~32'h1f800000) | 32'h90000000);
    chk("second used", 32'h20, 32'(sysDivider));
    apb(1'b1, OFF_POWER_CTRL, 32'h1);
    chk("hibernate req", 32'h1, 32'(hibernateReq));
    apb(1'b1, OFF_POWER_CTRL, 32'h0);
    chk("hibernate off", 32'h0, 32'(hibernateReq));
    $display("test secondary done");
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    test_done;
  end

  initial begin
    {rst_n, psel, penable, pwrite, wait_for_interrupt_instr, dse, wake, debug_access_port} = '0;
    paddr = '0;
    pwdata = '0;
    n_fail = 0;
    num_checks = 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset;
    t_lock;
    t_crystal;
    t_sleep;
    t_deep;
    t_second;
    test_done;
  end
endmodule // plscc_top_bench
`default_nettype wire
